/* File: pss_capture.sv */
// snapshot capture unit: event sources, array and move sequencing
// How it works
// - up to 1024 entries; a capture appends all active positions.
// - events from key two, external input, software or trigger output.
// - global enable gates keys, external and trigger events, not host move requests; 0 off, 1 on, on after reset.
// - enable writes clear latched keys and waiting moves.
// - mode writes clear latched keys and waiting moves.
// - polarity 0 falling edge, 1 rising edge.
// - external input debounced 0 to 255 whole ms.
// - filter time zero bypasses debouncing.
// - mode 0 to 8, reset to 0.
// - modes 1 and 5 step to next entry per event, wrapping.
// - modes 4 and 5 are 0 and 1 on the external input.
// - mode 6 holds waiting requests until an external event.
// - mode 8 captures on trigger events, not software ones.
// - a capture stores the analog sample too.
// - captures and moves cover all active axes.
// - mode 2 keys: back, forward, staging+first, staging+home.
// - mode 2 stepping works only after key three, until key four.
// - staging uses secondary velocity, then goes on to the target.
// - mode 7 keys: load, auto step, pause/resume, step back.
// - mode 3 key two runs a path through all entries when idle.
// - software events 1 to 4 act as keys one to four.
// - count tracks valid entries; writes only clear or reduce it.
// - index below count picks the move entry; captures append.
// - per-axis wait bit: 1 waits in mode 6, 0 starts.
`timescale 1ns/1ns
module pss_capture #(
  parameter int CYC_PER_MS = pss_pkg::CYC_PER_MS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [31:0] rdata_o,
  input wire logic [3:0] hand_input_device_key_i,
  input wire logic snap_in_i,
  input wire logic trig_out_event_i,
  input wire logic [pss_pkg::AXES-1:0] active_axes_i,
  input wire logic [pss_pkg::AXES*pss_pkg::POS_W-1:0] axis_pos_i,
  input wire logic [pss_pkg::ADC_W-1:0] aux_analog_input_i,
  input wire logic all_idle_i,
  input wire logic move_done_i,
  input wire logic [pss_pkg::AXES-1:0] host_move_req_i,
  output logic [pss_pkg::AXES-1:0] axis_start_o,
  output logic move_req_o,
  output logic [1:0] move_kind_o,
  output logic move_secvel_o,
  output logic [pss_pkg::AXES-1:0] move_axes_o,
  output logic [pss_pkg::AXES*pss_pkg::POS_W-1:0] move_pos_o
);

  typedef struct packed {
    logic en;
    logic pol;
    logic [7:0] filt;
    logic [3:0] mode;
    logic [10:0] cnt;
    logic [9:0] idx;
    logic [3:0] waitax;
    logic [15:0] dly;
    logic [9:0] sel;
    logic s1;
    logic s2;
    logic deb;
    logic debp;
    logic [16:0] mscyc;
    logic [7:0] dbcnt;
    logic [15:0] dlycnt;
    logic [3:0] keyl;
    logic armed;
    logic paused;
    logic backp;
    pss_pkg::pss_st_e st;
    logic [3:0] pend;
    logic mreq;
    logic [1:0] mkind;
    logic [3:0] maxes;
    logic [3:0] astart;
    logic [31:0] rdata;
  } pss_state_s;

  localparam logic [16:0] MS_LAST = 17'(CYC_PER_MS - 1);

  pss_state_s state_reg;
  pss_state_s state_next;
  logic [pss_pkg::ENT_W-1:0] mem [pss_pkg::DEPTH];
  logic [pss_pkg::ENT_W-1:0] tgt_reg;
  logic [pss_pkg::ENT_W-1:0] ent_reg;
  logic cap_now;
  logic [9:0] tsel;
  logic [pss_pkg::ENT_W-1:0] cap_word;

  function automatic logic [9:0] idx_next(input logic [9:0] i, input logic [10:0] c);
    logic [10:0] s;
    s = {1'b0, i} + 11'h001;
    idx_next = (s >= c) ? 10'h000 : s[9:0];
  endfunction : idx_next

  function automatic logic [9:0] idx_prev(input logic [9:0] i, input logic [10:0] c);
    logic [10:0] l;
    l = c - 11'h001;
    idx_prev = (i == 10'h000) ? l[9:0] : i - 10'h001;
  endfunction : idx_prev

  function automatic logic is_last(input logic [9:0] i, input logic [10:0] c);
    is_last = ({1'b0, i} + 11'h001) >= c;
  endfunction : is_last

  function automatic logic [1:0] lowest(input logic [3:0] k);
    lowest = k[0] ? 2'h0 : k[1] ? 2'h1 : k[2] ? 2'h2 : 2'h3;
  endfunction : lowest

  always_comb begin
    logic tick;
    logic ext_ev;
    logic clr;
    logic hold;
    logic has;
    logic auto;
    logic f2;
    logic [3:0] sw;
    logic [3:0] newk;
    logic [3:0] avail;
    logic [1:0] k;
    tick = 1'b0;
    ext_ev = 1'b0;
    clr = 1'b0;
    hold = 1'b0;
    has = 1'b0;
    auto = 1'b0;
    f2 = 1'b0;
    sw = 4'h0;
    newk = 4'h0;
    avail = 4'h0;
    k = 2'h0;
    state_next = state_reg;
    cap_now = 1'b0;
    tsel = state_reg.idx;
    state_next.mreq = 1'b0;
    state_next.astart = 4'h0;
    state_next.rdata = 32'h0000_0000;

    // only the second sync stage feeds the filter
    state_next.s1 = snap_in_i;
    state_next.s2 = state_reg.s1;
    tick = state_reg.mscyc == MS_LAST;
    state_next.mscyc = tick ? 17'h00000 : state_reg.mscyc + 17'h00001;

    // new level must hold for the whole filter time
    if (state_reg.filt == 8'h00) begin
      state_next.deb = state_reg.s2;
      state_next.dbcnt = 8'h00;
    end else if (state_reg.s2 == state_reg.deb) begin
      state_next.dbcnt = 8'h00;
    end else if (tick) begin
      if (state_reg.dbcnt >= state_reg.filt) begin
        state_next.deb = state_reg.s2;
        state_next.dbcnt = 8'h00;
      end else begin
        state_next.dbcnt = state_reg.dbcnt + 8'h01;
      end
    end
    state_next.debp = state_reg.deb;
    ext_ev = state_reg.en && (state_reg.deb != state_reg.debp) && (state_reg.deb == state_reg.pol);

    if (we_i) begin
      case (addr_i)
        pss_pkg::OFS_ENABLE: begin
          state_next.en = wdata_i[0];
          clr = 1'b1;
        end
        pss_pkg::OFS_POLARITY: state_next.pol = wdata_i[0];
        pss_pkg::OFS_FILTER: state_next.filt = wdata_i[7:0];
        pss_pkg::OFS_MODE: begin
          if (wdata_i[31:4] == 28'h0 && wdata_i[3:0] <= pss_pkg::MODE_CAP_TRIG) begin
            state_next.mode = wdata_i[3:0];
            clr = 1'b1;
          end
        end
        pss_pkg::OFS_COUNT: begin
          if (wdata_i[31:11] == 21'h0 && wdata_i[10:0] <= state_reg.cnt) begin
            state_next.cnt = wdata_i[10:0];
            if ({1'b0, state_reg.idx} >= wdata_i[10:0]) begin
              state_next.idx = 10'h000;
            end
          end
        end
        pss_pkg::OFS_INDEX: begin
          if (wdata_i[31:10] == 22'h0 && {1'b0, wdata_i[9:0]} < state_reg.cnt) begin
            state_next.idx = wdata_i[9:0];
          end
        end
        pss_pkg::OFS_WAIT_AXES: state_next.waitax = wdata_i[3:0];
        pss_pkg::OFS_EVENT: begin
          if (wdata_i[31:3] == 29'h0 && wdata_i[2:0] != 3'h0 && wdata_i[2:0] <= 3'h4) begin
            sw = 4'h1 << (wdata_i[1:0] - 2'h1);
          end
        end
        pss_pkg::OFS_DELAY: state_next.dly = wdata_i[15:0];
        pss_pkg::OFS_ENTRY_SEL: state_next.sel = wdata_i[9:0];
        default: ;
      endcase
    end

    // key two source depends on mode
    if (state_reg.mode == pss_pkg::MODE_CAP_EXT || state_reg.mode == pss_pkg::MODE_STEP_EXT) begin
      f2 = ext_ev | sw[1];
    end else begin
      f2 = hand_input_device_key_i[1] | sw[1];
    end
    newk = {hand_input_device_key_i[3] | sw[3], hand_input_device_key_i[2] | sw[2], f2,
            hand_input_device_key_i[0] | sw[0]};
    if (!state_reg.en || state_reg.mode == pss_pkg::MODE_CAP_TRIG) begin
      newk = 4'h0;
    end
    state_next.keyl = clr ? 4'h0 : state_reg.keyl;

    // triggered start: held requests go out on the event
    hold = state_reg.en && state_reg.mode == pss_pkg::MODE_TRIG_START;
    state_next.pend = clr ? 4'h0 : state_reg.pend;
    if (hold && ext_ev) begin
      state_next.astart = state_next.pend;
      state_next.pend = 4'h0;
    end
    if (hold) begin
      state_next.pend = state_next.pend | (host_move_req_i & state_reg.waitax);
      state_next.astart = state_next.astart | (host_move_req_i & ~state_reg.waitax);
    end else begin
      state_next.astart = state_next.astart | host_move_req_i;
    end

    if (state_reg.en && state_reg.mode == pss_pkg::MODE_CAP_TRIG && trig_out_event_i) begin
      cap_now = state_reg.cnt < pss_pkg::DEPTH_CNT;
    end

    has = state_reg.cnt != 11'h000;
    auto = state_reg.st == pss_pkg::ST_AUTO_MOVE || state_reg.st == pss_pkg::ST_AUTO_DLY;

    // sequencing on move completion and on the end of the auto step delay
    unique case (state_reg.st)
      pss_pkg::ST_IDLE: ;
      pss_pkg::ST_STG_FIRST: begin
        if (move_done_i) begin
          state_next.idx = 10'h000;
          tsel = 10'h000;
          state_next.mreq = 1'b1;
          state_next.mkind = pss_pkg::MK_ENTRY;
          state_next.st = pss_pkg::ST_IDLE;
        end
      end
      pss_pkg::ST_STG_HOME: begin
        if (move_done_i) begin
          state_next.mreq = 1'b1;
          state_next.mkind = pss_pkg::MK_HOME;
          state_next.st = pss_pkg::ST_IDLE;
        end
      end
      pss_pkg::ST_PATH: begin
        if (move_done_i) begin
          if (is_last(state_reg.idx, state_reg.cnt)) begin
            state_next.st = pss_pkg::ST_IDLE;
          end else begin
            state_next.idx = idx_next(state_reg.idx, state_reg.cnt);
            tsel = state_next.idx;
            state_next.mreq = 1'b1;
            state_next.mkind = pss_pkg::MK_PATH;
          end
        end
      end
      pss_pkg::ST_AUTO_MOVE: begin
        if (move_done_i) begin
          state_next.dlycnt = 16'h0000;
          if (state_reg.backp) begin
            state_next.backp = 1'b0;
            state_next.paused = 1'b1;
            state_next.idx = idx_prev(state_reg.idx, state_reg.cnt);
            tsel = state_next.idx;
            state_next.mreq = 1'b1;
            state_next.mkind = pss_pkg::MK_ENTRY;
          end else begin
            state_next.st = pss_pkg::ST_AUTO_DLY;
          end
        end
      end
      pss_pkg::ST_AUTO_DLY: begin
        if (!state_reg.paused) begin
          if (tick) begin
            state_next.dlycnt = state_reg.dlycnt + 16'h0001;
          end
          if (state_reg.dlycnt >= state_reg.dly) begin
            if (is_last(state_reg.idx, state_reg.cnt)) begin
              state_next.st = pss_pkg::ST_IDLE;
            end else begin
              state_next.idx = idx_next(state_reg.idx, state_reg.cnt);
              tsel = state_next.idx;
              state_next.mreq = 1'b1;
              state_next.mkind = pss_pkg::MK_ENTRY;
              state_next.st = pss_pkg::ST_AUTO_MOVE;
            end
          end
        end
      end
    endcase

    // keys wait for an idle sequencer; auto takes only pause and back
    if (state_reg.st == pss_pkg::ST_IDLE) begin
      avail = state_reg.keyl;
    end else if (state_reg.mode == pss_pkg::MODE_CUSTOM && auto) begin
      avail = state_reg.keyl & 4'hc;
    end
    if (avail != 4'h0) begin
      k = lowest(avail);
      state_next.keyl[k] = 1'b0;
      case (state_reg.mode)
        pss_pkg::MODE_CAP_KEY, pss_pkg::MODE_CAP_EXT: begin
          if (k == 2'h1) begin
            cap_now = state_reg.cnt < pss_pkg::DEPTH_CNT;
          end
        end
        pss_pkg::MODE_STEP_KEY, pss_pkg::MODE_STEP_EXT: begin
          if (k == 2'h1 && has) begin
            tsel = state_reg.idx;
            state_next.idx = idx_next(state_reg.idx, state_reg.cnt);
            state_next.mreq = 1'b1;
            state_next.mkind = pss_pkg::MK_ENTRY;
          end
        end
        pss_pkg::MODE_EXTENDED: begin
          if (k == 2'h0 && state_reg.armed && has) begin
            state_next.idx = idx_prev(state_reg.idx, state_reg.cnt);
            tsel = state_next.idx;
            state_next.mreq = 1'b1;
            state_next.mkind = pss_pkg::MK_ENTRY;
          end else if (k == 2'h1 && state_reg.armed && has) begin
            state_next.idx = idx_next(state_reg.idx, state_reg.cnt);
            tsel = state_next.idx;
            state_next.mreq = 1'b1;
            state_next.mkind = pss_pkg::MK_ENTRY;
          end else if (k == 2'h2) begin
            state_next.armed = 1'b1;
            state_next.mreq = 1'b1;
            state_next.mkind = pss_pkg::MK_STAGE;
            state_next.st = pss_pkg::ST_STG_FIRST;
          end else if (k == 2'h3) begin
            state_next.armed = 1'b0;
            state_next.mreq = 1'b1;
            state_next.mkind = pss_pkg::MK_STAGE;
            state_next.st = pss_pkg::ST_STG_HOME;
          end
        end
        pss_pkg::MODE_PATH: begin
          if (k == 2'h1 && has && all_idle_i) begin
            state_next.idx = 10'h000;
            tsel = 10'h000;
            state_next.mreq = 1'b1;
            state_next.mkind = pss_pkg::MK_PATH;
            state_next.st = pss_pkg::ST_PATH;
          end
        end
        pss_pkg::MODE_CUSTOM: begin
          if (k == 2'h0) begin
            state_next.mreq = 1'b1;
            state_next.mkind = pss_pkg::MK_STAGE;
            state_next.st = pss_pkg::ST_STG_HOME;
          end else if (k == 2'h1 && has) begin
            state_next.idx = 10'h000;
            tsel = 10'h000;
            state_next.paused = 1'b0;
            state_next.backp = 1'b0;
            state_next.mreq = 1'b1;
            state_next.mkind = pss_pkg::MK_ENTRY;
            state_next.st = pss_pkg::ST_AUTO_MOVE;
          end else if (k == 2'h2 && auto) begin
            state_next.paused = ~state_reg.paused;
          end else if (k == 2'h3 && auto) begin
            if (state_reg.paused || state_reg.st == pss_pkg::ST_AUTO_DLY) begin
              state_next.paused = 1'b1;
              state_next.idx = idx_prev(state_reg.idx, state_reg.cnt);
              tsel = state_next.idx;
              state_next.mreq = 1'b1;
              state_next.mkind = pss_pkg::MK_ENTRY;
              state_next.st = pss_pkg::ST_AUTO_MOVE;
            end else begin
              state_next.backp = 1'b1;
            end
          end
        end
        default: ;
      endcase
    end
    state_next.keyl = state_next.keyl | newk;

    if (cap_now) begin
      state_next.cnt = state_reg.cnt + 11'h001;
    end
    if (state_next.mreq) begin
      state_next.maxes = active_axes_i;
    end

    if (re_i) begin
      case (addr_i)
        pss_pkg::OFS_ENABLE: state_next.rdata = {31'h0, state_reg.en};
        pss_pkg::OFS_POLARITY: state_next.rdata = {31'h0, state_reg.pol};
        pss_pkg::OFS_FILTER: state_next.rdata = {24'h0, state_reg.filt};
        pss_pkg::OFS_MODE: state_next.rdata = {28'h0, state_reg.mode};
        pss_pkg::OFS_COUNT: state_next.rdata = {21'h0, state_reg.cnt};
        pss_pkg::OFS_INDEX: state_next.rdata = {22'h0, state_reg.idx};
        pss_pkg::OFS_WAIT_AXES: state_next.rdata = {28'h0, state_reg.waitax};
        pss_pkg::OFS_DELAY: state_next.rdata = {16'h0, state_reg.dly};
        pss_pkg::OFS_STATUS: state_next.rdata = {18'h0, state_reg.keyl, state_reg.pend, state_reg.backp,
                                                  state_reg.paused, state_reg.armed, state_reg.st};
        pss_pkg::OFS_ENTRY_SEL: state_next.rdata = {22'h0, state_reg.sel};
        pss_pkg::OFS_ENTRY_VOLT: state_next.rdata = {20'h0, ent_reg[pss_pkg::ENT_W-1 -: pss_pkg::ADC_W]};
        default: begin
          if (addr_i[7:4] == pss_pkg::OFS_ENTRY_POS_HI && addr_i[1:0] == 2'h0) begin
            state_next.rdata = ent_reg[addr_i[3:2]*pss_pkg::POS_W +: pss_pkg::POS_W];
          end
        end
      endcase
    end
  end

  // inactive axes stored as zero
  always_comb begin
    cap_word = {aux_analog_input_i, axis_pos_i};
    for (int a = 0; a < pss_pkg::AXES; a++) begin
      if (!active_axes_i[a]) begin
        cap_word[a*pss_pkg::POS_W +: pss_pkg::POS_W] = '0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= '0;
      state_reg.en <= pss_pkg::RST_ENABLE;
      state_reg.pol <= pss_pkg::RST_POLARITY;
      state_reg.filt <= pss_pkg::RST_FILTER;
      state_reg.mode <= pss_pkg::RST_MODE;
      state_reg.dly <= pss_pkg::RST_DELAY;
      state_reg.st <= pss_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // array has no reset; its read registers do
  always_ff @(posedge clk_i) begin
    if (cap_now) begin
      mem[state_reg.cnt[9:0]] <= cap_word;
    end
    if (rst_i) begin
      tgt_reg <= '0;
      ent_reg <= '0;
    end else begin
      tgt_reg <= mem[tsel];
      ent_reg <= mem[state_next.sel];
    end
  end

  assign rdata_o = state_reg.rdata;
  assign axis_start_o = state_reg.astart;
  assign move_req_o = state_reg.mreq;
  assign move_kind_o = state_reg.mkind;
  assign move_secvel_o = state_reg.mkind == pss_pkg::MK_STAGE;
  assign move_axes_o = state_reg.maxes;
  assign move_pos_o = tgt_reg[pss_pkg::AXES*pss_pkg::POS_W-1:0];

endmodule : pss_capture

/* File: pss_capture_monitor.sv */
// port checker for the snapshot capture unit
`timescale 1ns/1ns
module pss_capture_mon (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  input wire logic [31:0] rdata_o,
  input wire logic [3:0] active_axes_i,
  input wire logic [3:0] host_move_req_i,
  input wire logic [3:0] axis_start_o,
  input wire logic move_req_o,
  input wire logic [1:0] move_kind_o,
  input wire logic move_secvel_o,
  input wire logic [3:0] move_axes_o
);
  // settings rebuilt from bus writes
  logic en_reg;
  logic pol_reg;
  logic [3:0] mode_reg;
  logic [3:0] wait_reg;
  logic m6;
  logic [3:0] hreq;
  logic [3:0] ireq;
  assign m6 = en_reg && mode_reg == pss_pkg::MODE_TRIG_START;
  assign hreq = m6 ? host_move_req_i & wait_reg : 4'h0;
  assign ireq = m6 ? host_move_req_i & ~wait_reg : host_move_req_i;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_reg <= pss_pkg::RST_ENABLE;
      pol_reg <= pss_pkg::RST_POLARITY;
      mode_reg <= pss_pkg::RST_MODE;
      wait_reg <= 4'h0;
    end else if (we_i) begin
      if (addr_i == pss_pkg::OFS_ENABLE) en_reg <= wdata_i[0];
      if (addr_i == pss_pkg::OFS_POLARITY) pol_reg <= wdata_i[0];
      if (addr_i == pss_pkg::OFS_MODE && wdata_i <= 32'h8) mode_reg <= wdata_i[3:0];
      if (addr_i == pss_pkg::OFS_WAIT_AXES) wait_reg <= wdata_i[3:0];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_rd_en; re_i && addr_i == pss_pkg::OFS_ENABLE |=> rdata_o == {31'h0, $past(en_reg)}; endproperty
  a_rd_en: assert property (p_rd_en) else $error("enable readback wrong");
  property p_rd_pol; re_i && addr_i == pss_pkg::OFS_POLARITY |=> rdata_o == {31'h0, $past(pol_reg)}; endproperty
  a_rd_pol: assert property (p_rd_pol) else $error("polarity readback wrong");
  property p_rd_mode; re_i && addr_i == pss_pkg::OFS_MODE |=> rdata_o == {28'h0, $past(mode_reg)}; endproperty
  a_rd_mode: assert property (p_rd_mode) else $error("mode readback wrong");
  property p_imm; |ireq |=> (axis_start_o & $past(ireq)) == $past(ireq); endproperty
  a_imm: assert property (p_imm) else $error("request not started");
  property p_hold; |hreq |=> (axis_start_o & $past(hreq)) == 4'h0; endproperty
  a_hold: assert property (p_hold) else $error("waiting axis started early");
  property p_secvel; move_secvel_o == (move_kind_o == pss_pkg::MK_STAGE); endproperty
  a_secvel: assert property (p_secvel) else $error("staging speed flag wrong");
  property p_axes; move_req_o |-> move_axes_o == $past(active_axes_i); endproperty
  a_axes: assert property (p_axes) else $error("move axes wrong");
  property p_kind; !move_req_o |-> $stable(move_kind_o); endproperty
  a_kind: assert property (p_kind) else $error("kind changed without request");
  c_stage: cover property (move_req_o && move_kind_o == pss_pkg::MK_STAGE);
  c_start: cover property (|axis_start_o);
  c_read: cover property (re_i && addr_i == pss_pkg::OFS_MODE);
endmodule : pss_capture_mon
bind pss_capture pss_capture_mon i_pss_capture_mon (.*);

/* File: pss_motion_model.sv */
// motion engine stand-in with a set latency
`timescale 1ns/1ns
module pss_motion_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic move_req_i,
  input wire logic [7:0] lat_i,
  output logic move_done_o,
  output logic idle_o
);
  logic busy_reg;
  logic [7:0] cnt_reg;
  // a request while busy restarts the count
  assign idle_o = !busy_reg;
  always_ff @(posedge clk_i) begin
    move_done_o <= 1'b0;
    if (rst_i) begin
      busy_reg <= 1'b0;
      cnt_reg <= 8'h0;
    end else if (move_req_i) begin
      busy_reg <= 1'b1;
      cnt_reg <= lat_i;
    end else if (busy_reg && cnt_reg == 8'h0) begin
      busy_reg <= 1'b0;
      move_done_o <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg - 8'h1;
    end
  end
endmodule : pss_motion_model

/* File: pss_pkg.sv */
// constants and types of the snapshot capture unit
package pss_pkg;
  localparam int CLK_MHZ = 125;
  localparam int FILT_UNIT_MS = 1;
  localparam int CYC_PER_MS = CLK_MHZ * 1000 * FILT_UNIT_MS;
  localparam int DEPTH = 1024;
  localparam int AXES = 4;
  localparam int POS_W = 32;
  localparam int ADC_W = 12;
  localparam int ENT_W = AXES * POS_W + ADC_W;
  localparam logic [10:0] DEPTH_CNT = 11'h400;

  localparam logic [7:0] OFS_ENABLE = 8'h00;
  localparam logic [7:0] OFS_POLARITY = 8'h04;
  localparam logic [7:0] OFS_FILTER = 8'h08;
  localparam logic [7:0] OFS_MODE = 8'h0c;
  localparam logic [7:0] OFS_COUNT = 8'h10;
  localparam logic [7:0] OFS_INDEX = 8'h14;
  localparam logic [7:0] OFS_WAIT_AXES = 8'h18;
  localparam logic [7:0] OFS_EVENT = 8'h1c;
  localparam logic [7:0] OFS_DELAY = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [7:0] OFS_ENTRY_SEL = 8'h28;
  localparam logic [3:0] OFS_ENTRY_POS_HI = 4'h3;
  localparam logic [7:0] OFS_ENTRY_VOLT = 8'h40;

  localparam logic RST_ENABLE = 1'b1;
  localparam logic RST_POLARITY = 1'b1;
  localparam logic [7:0] RST_FILTER = 8'h00;
  localparam logic [3:0] RST_MODE = 4'h0;
  localparam logic [15:0] RST_DELAY = 16'h0000;

  localparam logic [3:0] MODE_CAP_KEY = 4'h0;
  localparam logic [3:0] MODE_STEP_KEY = 4'h1;
  localparam logic [3:0] MODE_EXTENDED = 4'h2;
  localparam logic [3:0] MODE_PATH = 4'h3;
  localparam logic [3:0] MODE_CAP_EXT = 4'h4;
  localparam logic [3:0] MODE_STEP_EXT = 4'h5;
  localparam logic [3:0] MODE_TRIG_START = 4'h6;
  localparam logic [3:0] MODE_CUSTOM = 4'h7;
  localparam logic [3:0] MODE_CAP_TRIG = 4'h8;

  localparam logic [1:0] MK_ENTRY = 2'h0;
  localparam logic [1:0] MK_STAGE = 2'h1;
  localparam logic [1:0] MK_HOME = 2'h2;
  localparam logic [1:0] MK_PATH = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_STG_FIRST = 3'b001,
    ST_STG_HOME = 3'b010,
    ST_PATH = 3'b011,
    ST_AUTO_MOVE = 3'b100,
    ST_AUTO_DLY = 3'b101
  } pss_st_e;
endpackage : pss_pkg

/* File: tb.sv */
// self-checking bench for the snapshot capture unit
`timescale 1ns/1ns
module tb;
  localparam logic [7:0] EN = pss_pkg::OFS_ENABLE;
  localparam logic [7:0] MD = pss_pkg::OFS_MODE;
  localparam logic [7:0] CN = pss_pkg::OFS_COUNT;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic we_i = 1'b0;
  logic re_i = 1'b0;
  logic snap_in_i = 1'b0;
  logic trig_out_event_i = 1'b0;
  logic clr = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic [3:0] hand_input_device_key_i = 4'h0;
  logic [3:0] host_move_req_i = 4'h0;
  logic [3:0] active_axes_i = 4'h7;
  logic [127:0] axis_pos_i = 128'h0;
  logic [11:0] aux_analog_input_i = 12'h0;
  logic [7:0] lat = 8'h4;
  logic [7:0] khist = 8'h0;
  logic [3:0] st = 4'h0;
  logic [31:0] lfsr = 32'h03f26e71;
  logic [31:0] rdata_o;
  logic [3:0] axis_start_o;
  logic [3:0] move_axes_o;
  logic [1:0] move_kind_o;
  logic [127:0] move_pos_o;
  logic [127:0] lpos;
  logic [127:0] ent [3];
  logic move_req_o, move_secvel_o, all_idle_i, move_done_i;
  int n_errors = 0, cmp_count = 0, cyc = 0, n_req = 0, n0;
  pss_capture #(.CYC_PER_MS(8)) i_pss_capture (.clk_i, .rst_i, .addr_i, .wdata_i, .we_i, .re_i, .rdata_o,
    .hand_input_device_key_i, .snap_in_i, .trig_out_event_i, .active_axes_i, .axis_pos_i, .aux_analog_input_i,
    .all_idle_i, .move_done_i, .host_move_req_i, .axis_start_o, .move_req_o, .move_kind_o, .move_secvel_o,
    .move_axes_o, .move_pos_o);
  pss_motion_model i_pss_motion_model (.clk_i, .rst_i, .move_req_i(move_req_o), .lat_i(lat),
    .move_done_o(move_done_i), .idle_o(all_idle_i));
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    st <= clr ? 4'h0 : (st | axis_start_o);
    if (move_req_o === 1'b1) begin
      n_req <= n_req + 1;
      khist <= {khist[5:0], move_kind_o};
      lpos <= move_pos_o;
    end
    if (cyc == 40000) begin
      n_errors++;
      stop_test();
    end
  end
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  function automatic logic [127:0] msk(input logic [127:0] p, input logic [3:0] a);
    for (int i = 0; i < 4; i++) if (!a[i]) p[i*32+:32] = 32'h0;
    return p;
  endfunction : msk
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr_i <= a;
    wdata_i <= d;
    we_i <= 1'b1;
    tick(1);
    we_i <= 1'b0;
    tick(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    addr_i <= a;
    re_i <= 1'b1;
    tick(1);
    re_i <= 1'b0;
    tick(1);
    chk(rdata_o, e);
  endtask : rd
  // random motion latency
  task automatic kp(input logic [3:0] k);
    lfsr = nxt(lfsr);
    lat <= {5'h0, lfsr[2:0]};
    hand_input_device_key_i <= k;
    tick(1);
    hand_input_device_key_i <= 4'h0;
    tick(40);
  endtask : kp
  task automatic ep(input logic lv, input int n);
    snap_in_i <= lv;
    tick(n);
    snap_in_i <= !lv;
    tick(n);
  endtask : ep
  task automatic tp();
    trig_out_event_i <= 1'b1;
    tick(1);
    trig_out_event_i <= 1'b0;
    tick(1);
  endtask : tp
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  initial begin
    tick(12);
    rst_i <= 1'b0;
    tick(1);
    rd(EN, 32'h1);
    rd(pss_pkg::OFS_POLARITY, 32'h1);
    rd(pss_pkg::OFS_FILTER, 32'h0);
    rd(MD, 32'h0);
    rd(CN, 32'h0);
    for (int i = 0; i < 3; i++) begin
      lfsr = nxt(lfsr);
      axis_pos_i <= {lfsr, ~lfsr, lfsr ^ 32'h5a5a5a5a, lfsr + 32'h1};
      aux_analog_input_i <= lfsr[11:0];
      if (i == 0) kp(4'h2);
      else if (i == 1) wr(pss_pkg::OFS_EVENT, 32'h2);
      else begin
        wr(MD, 32'h4);
        ep(1'b1, 6);
      end
      tick(20);
      ent[i] = msk(axis_pos_i, active_axes_i);
      wr(pss_pkg::OFS_ENTRY_SEL, i);
      tick(1);
      for (int a = 0; a < 4; a++) rd({pss_pkg::OFS_ENTRY_POS_HI, a[1:0], 2'b00}, ent[i][a*32+:32]);
      rd(pss_pkg::OFS_ENTRY_VOLT, {20'h0, aux_analog_input_i});
      rd(CN, i + 1);
    end
    kp(4'h2);
    rd(CN, 32'h3);
    wr(MD, 32'h8);
    wr(pss_pkg::OFS_EVENT, 32'h2);
    tick(5);
    rd(CN, 32'h3);
    tp();
    rd(CN, 32'h4);
    wr(EN, 32'h0);
    tp();
    rd(CN, 32'h4);
    wr(EN, 32'h1);
    wr(CN, 32'h5);
    rd(CN, 32'h4);
    wr(CN, 32'h2);
    rd(CN, 32'h2);
    wr(MD, 32'h1);
    for (int i = 0; i < 3; i++) begin
      kp(4'h2);
      chk(lpos, ent[i % 2]);
    end
    wr(pss_pkg::OFS_INDEX, 32'h2);
    rd(pss_pkg::OFS_INDEX, 32'h1);
    wr(MD, 32'h2);
    n0 = n_req;
    kp(4'h1);
    chk(n_req, n0);
    kp(4'h4);
    chk(khist[3:0], {pss_pkg::MK_STAGE, pss_pkg::MK_ENTRY});
    chk(lpos, ent[0]);
    kp(4'h2);
    chk(lpos, ent[1]);
    kp(4'h1);
    chk(lpos, ent[0]);
    kp(4'h8);
    chk(khist[3:0], {pss_pkg::MK_STAGE, pss_pkg::MK_HOME});
    n0 = n_req;
    kp(4'h2);
    chk(n_req, n0);
    wr(MD, 32'h6);
    snap_in_i <= 1'b1;
    wr(pss_pkg::OFS_POLARITY, 32'h0);
    wr(pss_pkg::OFS_WAIT_AXES, 32'h1);
    for (int k = 0; k < 3; k++) begin
      clr <= 1'b1;
      host_move_req_i <= 4'h3;
      tick(1);
      clr <= 1'b0;
      host_move_req_i <= 4'h0;
      tick(3);
      if (k == 1) wr(MD, 32'h6);
      if (k == 2) wr(EN, 32'h1);
      ep(1'b0, 6);
      chk(st, k == 0 ? 4'h3 : 4'h2);
    end
    snap_in_i <= 1'b0;
    wr(pss_pkg::OFS_POLARITY, 32'h1);
    wr(MD, 32'h4);
    wr(pss_pkg::OFS_FILTER, 32'h2);
    ep(1'b1, 12);
    rd(CN, 32'h2);
    ep(1'b1, 40);
    rd(CN, 32'h3);
    wr(MD, 32'h8);
    wr(CN, 32'h0);
    repeat (1025) tp();
    rd(CN, pss_pkg::DEPTH_CNT);
    stop_test();
  end
endmodule : tb
